//--- verilog/rlcc_pkg.sv
// Purpose: shared constants and carriers for the lane configuration control block
// Assumes: 40 MHz ref_clk, register port with one-cycle read latency
// Notes:   three-level strap pins arrive as a drive level plus a pull-test level
package rlcc_pkg;

   // --------
   // register offsets
   // --------
   localparam logic [7:0] REG_MISC     = 8'h09;  // lane swap, audio disable, signal detect
   localparam logic [7:0] REG_EQ_MODE  = 8'h0A;  // equaliser mode, function mode
   localparam logic [7:0] REG_TERM     = 8'h0B;  // termination select
   localparam logic [7:0] REG_EQ_GAIN  = 8'h0D;  // fixed gain code
   localparam logic [7:0] REG_ERR_CTL  = 8'h20;  // checker control, prbs enable
   localparam logic [7:0] REG_ERR_L0   = 8'h21;  // lane error counts follow
   localparam logic [7:0] REG_STATUS   = 8'h24;  // resolved state

   // --------
   // field positions
   // --------
   localparam int SWAP_BIT      = 7;
   localparam int ARC_DIS_BIT   = 4;
   localparam int SIGDET_BIT    = 0;
   localparam int EQ_FIX_BIT    = 5;  // 1 selects fixed gain
   localparam int EQ_OVR_BIT    = 4;  // register overrides strap
   localparam int TERM_LSB      = 3;
   localparam int TERM_OVR_BIT  = 5;
   localparam int GAIN_LSB      = 1;
   localparam int GAIN_W        = 5;
   localparam int MODE_LSB      = 0;

   // --------
   // reset values and codes
   // --------
   localparam logic [7:0] MISC_RST    = 8'h00;
   localparam logic [7:0] EQ_MODE_RST = 8'h03;  // automatic crossover
   localparam logic [7:0] TERM_RST    = 8'h00;
   localparam logic [7:0] GAIN_RST    = 8'h00;
   localparam logic [4:0] GAIN_14DB   = 5'h1C;  // strap high fixed gain
   localparam logic [4:0] GAIN_7P5DB  = 5'h0F;  // strap low fixed gain
   localparam logic [1:0] MODE_REDRV  = 2'h0;
   localparam logic [1:0] MODE_RETIME = 2'h1;
   localparam logic [1:0] MODE_AUTO   = 2'h3;

   // --------
   // timing
   // --------
   localparam int CLK_NS         = 25;
   localparam int LINK_TMO_NS    = 2000;  // no link clock edge within this: clock absent
   localparam int LINK_TMO_CYC   = LINK_TMO_NS / CLK_NS;
   localparam int STRAP_SETTLE   = 4;     // cycles after enable before straps are caught

   typedef enum logic [1:0] {
      TERM_NONE = 2'h0,
      TERM_LOW  = 2'h1,  // 75 to 150 ohm
      TERM_MID  = 2'h2   // 150 to 300 ohm
   } rlcc_term_e;

   typedef enum logic [1:0] {
      LVL_LOW = 2'h0,
      LVL_HIGH = 2'h1,
      LVL_FLOAT = 2'h2
   } rlcc_lvl_e;

   // data rate class reported by the rate detector
   typedef struct packed {
      logic above_1g;
      logic above_2g;
      logic above_3g4;
   } rlcc_rate_s;

   // one input or output lane set: clock, d2, d1, d0
   typedef struct packed {
      logic clk;
      logic d2;
      logic d1;
      logic d0;
   } rlcc_lanes_s;

endpackage : rlcc_pkg

//--- verilog/rlcc_top.sv
// Purpose: control and configuration logic of a four-lane video retimer
// Assumes: three-level straps sampled as drive level plus level seen under a weak pull
// Notes:   lane data here stands for recovered bit streams at ref_clk rate
//
// Overview of operation
// RULE1: enable low ignores controls, lanes high impedance
// RULE2: host holds enable low at least 100 us
// RULE3: raising enable clears register configuration
// RULE4: swap maps d2-clk, d1-d0, d0-d1, clk-d2
// RULE5: swap when strap low or register bit
// RULE6: equaliser settings follow remapped lanes
// RULE7: swap works in redriver and retimer
// RULE8: strap high inverts every input lane
// RULE9: polarity inversion only in retimer mode
// RULE10: per data lane error count readable
// RULE11: prbs source on data lanes, needs clock
// RULE12: eq strap high 14dB, low 7.5dB, float adaptive
// RULE13: adaptive only retimer; register selects too
// RULE14: register field selects fixed gain everywhere
// RULE15: adaptive equalisation selected after reset
// RULE16: no clock with detect on: standby
// RULE17: detect enabled by strap or register
// RULE18: audio input passes to audio output
// RULE19: audio output on, software may disable
// RULE20: termination strap high none, low, float auto
// RULE21: register selects termination like strap
// RULE22: auto mode redriver below about 1 Gbps
// RULE23: three-level straps caught at enable rise
`timescale 1ns/1ps
`default_nettype none

module rlcc_top #(
   parameter int LANES = 3
) (
   input  wire logic               ref_clk,
   input  wire logic               resetn,          // synchronous, also the enable pin
   // register port
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [7:0]         reg_rdata,
   // straps: drive level and level seen with the weak pull applied; signal detect is drive level only
   input  wire logic               lane_swap_polarity_strap,
   input  wire logic               lane_swap_polarity_strap_pull,
   input  wire logic               equalizer_strap_pin,
   input  wire logic               equalizer_strap_pin_pull,
   input  wire logic               signal_detect_enable,
   input  wire logic               output_termination_select,
   input  wire logic               output_termination_select_pull,
   // link side
   input  wire rlcc_pkg::rlcc_lanes_s rx_lanes,     // clk, rx_data_lane2..0
   input  wire rlcc_pkg::rlcc_rate_s  rate_class,   // from analog rate detector
   output rlcc_pkg::rlcc_lanes_s      tx_lanes,     // clk, tx_data_lane2..0
   output logic                    tx_lanes_oe_n,   // low while lanes are driven
   output logic      [4*5-1:0]     lane_eq_gain,    // per output lane: clk,d2,d1,d0
   output logic      [3:0]         lane_eq_adapt,
   output logic      [1:0]         tx_term_sel,
   output logic                    cdr_enable,
   output logic                    retimer_active,
   // audio return
   input  wire logic               audio_in,
   output logic                    audio_return_output,
   output logic                    audio_return_oe_n
);

   if (LANES != 3) begin : g_lane_chk
      $error("rlcc_top serves exactly three data lanes");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   localparam int NSYNC = 15;
   logic [NSYNC-1:0] sync1_ff;
   logic [NSYNC-1:0] sync2_ff;
   always_ff @(posedge ref_clk) begin
      sync1_ff <= {lane_swap_polarity_strap, lane_swap_polarity_strap_pull,
                   equalizer_strap_pin, equalizer_strap_pin_pull,
                   signal_detect_enable, output_termination_select,
                   output_termination_select_pull, rx_lanes, rate_class, audio_in};
      sync2_ff <= sync1_ff;
   end
   logic                  s_swap;
   logic                  s_swap_pull;
   logic                  s_eq;
   logic                  s_eq_pull;
   logic                  s_sig;
   logic                  s_term;
   logic                  s_term_pull;
   rlcc_pkg::rlcc_lanes_s s_rx;
   rlcc_pkg::rlcc_rate_s  s_rate;
   logic                  s_audio;
   assign {s_swap, s_swap_pull, s_eq, s_eq_pull, s_sig, s_term, s_term_pull,
           s_rx, s_rate, s_audio} = sync2_ff;

   // a floating pin follows the pull; a driven one does not
   function automatic rlcc_pkg::rlcc_lvl_e lvl3(input logic d, input logic p);
      if (d != p) lvl3 = rlcc_pkg::LVL_FLOAT;
      else if (d) lvl3 = rlcc_pkg::LVL_HIGH;
      else lvl3 = rlcc_pkg::LVL_LOW;
   endfunction : lvl3

   // ----------------------------------------------------------------
   // strap capture after enable release
   // ----------------------------------------------------------------
   logic [2:0]          settle_ff;
   logic                straps_ok_ff;
   rlcc_pkg::rlcc_lvl_e swap_lvl_ff;
   rlcc_pkg::rlcc_lvl_e eq_lvl_ff;
   rlcc_pkg::rlcc_lvl_e term_lvl_ff;
   logic                sig_strap_ff;
   // wait for synchronisers to fill before catching levels
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         settle_ff    <= 3'h0;
         straps_ok_ff <= 1'b0;
      end else if (!straps_ok_ff) begin
         settle_ff    <= settle_ff + 3'h1;
         straps_ok_ff <= (settle_ff == 3'(rlcc_pkg::STRAP_SETTLE)); // RULE23
      end
   end
   // levels caught once, held until next reset
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         swap_lvl_ff  <= rlcc_pkg::LVL_HIGH;
         eq_lvl_ff    <= rlcc_pkg::LVL_FLOAT;
         term_lvl_ff  <= rlcc_pkg::LVL_FLOAT;
         sig_strap_ff <= 1'b0;
      end else if (!straps_ok_ff && settle_ff == 3'(rlcc_pkg::STRAP_SETTLE)) begin
         swap_lvl_ff  <= lvl3(s_swap, s_swap_pull);   // RULE23
         eq_lvl_ff    <= lvl3(s_eq, s_eq_pull);       // RULE23
         term_lvl_ff  <= lvl3(s_term, s_term_pull);   // RULE23
         sig_strap_ff <= s_sig;
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   logic [7:0] misc_ff;
   logic [7:0] eqm_ff;
   logic [7:0] term_ff;
   logic [7:0] gain_ff;
   logic [7:0] errc_ff;
   // enable low clears everything, so software must rewrite after enable rises
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin                               // RULE1 RULE3
         misc_ff <= rlcc_pkg::MISC_RST;
         eqm_ff  <= rlcc_pkg::EQ_MODE_RST;
         term_ff <= rlcc_pkg::TERM_RST;
         gain_ff <= rlcc_pkg::GAIN_RST;
         errc_ff <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            rlcc_pkg::REG_MISC:    misc_ff <= reg_wdata;
            rlcc_pkg::REG_EQ_MODE: eqm_ff  <= reg_wdata;
            rlcc_pkg::REG_TERM:    term_ff <= reg_wdata;
            rlcc_pkg::REG_EQ_GAIN: gain_ff <= reg_wdata;
            rlcc_pkg::REG_ERR_CTL: errc_ff <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // link clock presence and operating mode
   // ----------------------------------------------------------------
   localparam int TW = $clog2(rlcc_pkg::LINK_TMO_CYC + 1);
   logic          clk_prev_ff;
   logic [TW-1:0] tmo_ff;
   logic          clk_valid_ff;
   // any edge of the sampled link clock restarts the timeout
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         clk_prev_ff  <= s_rx.clk;  // no false edge at release
         tmo_ff       <= '0;
         clk_valid_ff <= 1'b0;
      end else begin
         clk_prev_ff <= s_rx.clk;
         if (s_rx.clk != clk_prev_ff) begin
            tmo_ff       <= '0;
            clk_valid_ff <= 1'b1;
         end else if (tmo_ff == TW'(rlcc_pkg::LINK_TMO_CYC)) begin
            clk_valid_ff <= 1'b0;
         end else begin
            tmo_ff <= tmo_ff + TW'(1);
         end
      end
   end

   logic sigdet_on;
   logic standby;
   logic [1:0] fmode;
   logic retime;
   assign sigdet_on = sig_strap_ff | misc_ff[rlcc_pkg::SIGDET_BIT];   // RULE17
   assign standby   = sigdet_on & ~clk_valid_ff;                      // RULE16
   assign fmode     = eqm_ff[rlcc_pkg::MODE_LSB +: 2];
   // automatic crossover around 1 Gbps
   assign retime    = (fmode == rlcc_pkg::MODE_AUTO) ? s_rate.above_1g  // RULE22
                    : (fmode != rlcc_pkg::MODE_REDRV);

   // ----------------------------------------------------------------
   // lane swap and polarity
   // ----------------------------------------------------------------
   logic swap_on;
   logic pol_on;
   rlcc_pkg::rlcc_lanes_s rx_pol;
   rlcc_pkg::rlcc_lanes_s routed;
   assign swap_on = (swap_lvl_ff == rlcc_pkg::LVL_LOW) | misc_ff[rlcc_pkg::SWAP_BIT]; // RULE5
   assign pol_on  = (swap_lvl_ff == rlcc_pkg::LVL_HIGH) & retime;     // RULE8 RULE9
   assign rx_pol  = pol_on ? ~s_rx : s_rx;                            // RULE8
   // routing does not depend on the operating mode
   always_comb begin
      if (swap_on) begin                                              // RULE4 RULE7
         routed.clk = rx_pol.d2;
         routed.d0  = rx_pol.d1;
         routed.d1  = rx_pol.d0;
         routed.d2  = rx_pol.clk;
      end else begin
         routed = rx_pol;
      end
   end

   // ----------------------------------------------------------------
   // prbs source (x^7+x^6+1)
   // ----------------------------------------------------------------
   logic [6:0] prbs_ff;
   logic       prbs_on;
   logic       clk_edge;
   assign prbs_on  = errc_ff[1];
   assign clk_edge = s_rx.clk & ~clk_prev_ff;
   // advances on rising input clock edges so output rate follows the source clock
   always_ff @(posedge ref_clk) begin
      if (!resetn) prbs_ff <= 7'h7F;
      else if (prbs_on && clk_edge) prbs_ff <= {prbs_ff[5:0], prbs_ff[6] ^ prbs_ff[5]}; // RULE11
   end

   // ----------------------------------------------------------------
   // output lanes
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         tx_lanes <= '0;
      end else if (prbs_on) begin
         tx_lanes <= {routed.clk, {3{prbs_ff[6]}}};                   // RULE11
      end else begin
         tx_lanes <= routed;
      end
   end
   // lanes float in reset and in standby
   always_ff @(posedge ref_clk) begin
      if (!resetn) tx_lanes_oe_n <= 1'b1;                             // RULE1
      else tx_lanes_oe_n <= standby;                                  // RULE16
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cdr_enable     <= 1'b0;
         retimer_active <= 1'b0;
      end else begin
         cdr_enable     <= retime & ~standby;                         // RULE16
         retimer_active <= retime;
      end
   end

   // ----------------------------------------------------------------
   // equaliser selection
   // ----------------------------------------------------------------
   logic       eq_fixed;
   logic [4:0] eq_code;
   logic       adapt;
   // register override wins over the strap
   always_comb begin
      if (eqm_ff[rlcc_pkg::EQ_OVR_BIT]) begin                         // RULE13
         eq_fixed = eqm_ff[rlcc_pkg::EQ_FIX_BIT];
         eq_code  = gain_ff[rlcc_pkg::GAIN_LSB +: rlcc_pkg::GAIN_W];  // RULE14
      end else begin
         eq_fixed = (eq_lvl_ff != rlcc_pkg::LVL_FLOAT);               // RULE12 RULE15
         eq_code  = (eq_lvl_ff == rlcc_pkg::LVL_HIGH) ? rlcc_pkg::GAIN_14DB
                                                      : rlcc_pkg::GAIN_7P5DB; // RULE12
      end
   end
   // adaptive needs the retimer; redriver falls back to the fixed code
   assign adapt = ~eq_fixed & retime;                                 // RULE13
   // gain is one code on all four lanes, so it needs no reordering for the swap
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         lane_eq_gain  <= '0;
         lane_eq_adapt <= '0;
      end else begin
         lane_eq_gain  <= {4{eq_code}};                               // RULE14
         lane_eq_adapt <= swap_on ? {adapt, adapt, adapt, adapt}      // RULE6
                                  : {4{adapt}};
      end
   end

   // ----------------------------------------------------------------
   // termination
   // ----------------------------------------------------------------
   rlcc_pkg::rlcc_term_e term_auto;
   rlcc_pkg::rlcc_term_e term_pick;
   always_comb begin
      if (s_rate.above_3g4)     term_auto = rlcc_pkg::TERM_LOW;
      else if (s_rate.above_2g) term_auto = rlcc_pkg::TERM_MID;
      else                          term_auto = rlcc_pkg::TERM_NONE;
      if (term_ff[rlcc_pkg::TERM_OVR_BIT]) begin                      // RULE21
         case (term_ff[rlcc_pkg::TERM_LSB +: 2])
            2'h0:    term_pick = rlcc_pkg::TERM_NONE;
            2'h1:    term_pick = rlcc_pkg::TERM_LOW;
            default: term_pick = term_auto;
         endcase
      end else begin
         case (term_lvl_ff)                                           // RULE20
            rlcc_pkg::LVL_HIGH: term_pick = rlcc_pkg::TERM_NONE;
            rlcc_pkg::LVL_LOW:  term_pick = rlcc_pkg::TERM_LOW;
            default:            term_pick = term_auto;
         endcase
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) tx_term_sel <= rlcc_pkg::TERM_NONE;
      else tx_term_sel <= term_pick;
   end

   // ----------------------------------------------------------------
   // audio return pass-through
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         audio_return_output <= 1'b0;
         audio_return_oe_n   <= 1'b1;
      end else begin
         audio_return_output <= s_audio;                              // RULE18
         audio_return_oe_n   <= misc_ff[rlcc_pkg::ARC_DIS_BIT];       // RULE19
      end
   end

   // ----------------------------------------------------------------
   // error checker: prbs7 self-sync per data lane
   // ----------------------------------------------------------------
   logic [3*7-1:0] chk_ff;
   logic [3*8-1:0] err_ff;
   logic [2:0]     lane_bit;
   assign lane_bit = {routed.d2, routed.d1, routed.d0};
   generate
      for (genvar g = 0; g < 3; g++) begin : g_chk
         // counts saturate so a bad link shows as full scale, not a wrap
         always_ff @(posedge ref_clk) begin
            if (!resetn || errc_ff[2]) begin
               chk_ff[g*7 +: 7] <= 7'h00;
               err_ff[g*8 +: 8] <= 8'h00;
            end else if (errc_ff[0] && clk_edge) begin                // RULE10
               chk_ff[g*7 +: 7] <= {chk_ff[g*7 +: 6], lane_bit[g]};
               if ((chk_ff[g*7+6] ^ chk_ff[g*7+5]) != lane_bit[g]
                   && err_ff[g*8 +: 8] != 8'hFF)
                  err_ff[g*8 +: 8] <= err_ff[g*8 +: 8] + 8'h01;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            rlcc_pkg::REG_MISC:    reg_rdata <= misc_ff;
            rlcc_pkg::REG_EQ_MODE: reg_rdata <= eqm_ff;
            rlcc_pkg::REG_TERM:    reg_rdata <= term_ff;
            rlcc_pkg::REG_EQ_GAIN: reg_rdata <= gain_ff;
            rlcc_pkg::REG_ERR_CTL: reg_rdata <= errc_ff;
            rlcc_pkg::REG_ERR_L0:  reg_rdata <= err_ff[7:0];          // RULE10
            8'h22:                 reg_rdata <= err_ff[15:8];
            8'h23:                 reg_rdata <= err_ff[23:16];
            rlcc_pkg::REG_STATUS:  reg_rdata <= {1'b0, standby, retime, swap_on,
                                                 pol_on, adapt, term_pick};
            default:               reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

endmodule : rlcc_top

`default_nettype wire

//--- tb/rlcc_chk.sv
// Purpose: port checks for rlcc_top
// Assumes: straps steady between resets, mode register left at automatic
// Notes:   lane checks wait for straps to settle after each release
`timescale 1ns/1ps
`default_nettype none
module rlcc_chk (
   input wire logic                  ref_clk,
   input wire logic                  resetn,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire logic                  lane_swap_polarity_strap,
   input wire logic                  lane_swap_polarity_strap_pull,
   input wire logic                  signal_detect_enable,
   input wire logic                  output_termination_select,
   input wire logic                  output_termination_select_pull,
   input wire rlcc_pkg::rlcc_lanes_s rx_lanes,
   input wire rlcc_pkg::rlcc_rate_s  rx_rate,
   input wire rlcc_pkg::rlcc_lanes_s tx_lanes,
   input wire logic                  tx_lanes_oe_n,
   input wire logic [1:0]            tx_term_sel,
   input wire logic                  cdr_enable,
   input wire logic                  retimer_active,
   input wire logic                  audio_in,
   input wire logic                  audio_return_output,
   input wire logic                  audio_return_oe_n
);
   // --------
   // helper logic and assertions
   // --------
   logic [7:0]            up_ff;
   logic [7:0]            idle_ff;
   logic                  ok;
   rlcc_pkg::rlcc_lanes_s rx1_ff, rx2_ff, rx3_ff;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   assign ok = up_ff > 8'h0C;
   // cycles since release; saturates, never wraps
   always_ff @(posedge ref_clk) begin
      if (!resetn) up_ff <= 8'h00;
      else if (up_ff != 8'hFF) up_ff <= up_ff + 8'h01;
   end
   // lane history for the three-cycle latency
   always_ff @(posedge ref_clk) begin
      rx1_ff <= rx_lanes;
      rx2_ff <= rx1_ff;
      rx3_ff <= rx2_ff;
   end
   // cycles without a link clock change
   always_ff @(posedge ref_clk) begin
      if (rx_lanes.clk != rx1_ff.clk) idle_ff <= 8'h00;
      else if (idle_ff != 8'hFF) idle_ff <= idle_ff + 8'h01;
   end
   chk_reset_hiz: assert property (disable iff (1'b0) !resetn |=>
      tx_lanes_oe_n && audio_return_oe_n && tx_lanes == 4'h0) else $error("driven in reset");
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   chk_audio_pass: assert property (up_ff > 8'h03 && !audio_return_oe_n |->
      audio_return_output == $past(audio_in, 3)) else $error("audio not passed");
   chk_swap_map: assert property (ok && !tx_lanes_oe_n && !lane_swap_polarity_strap
      && !lane_swap_polarity_strap_pull |-> tx_lanes == {rx3_ff.d2, rx3_ff.clk, rx3_ff.d0,
      rx3_ff.d1}) else $error("swapped lanes wrong");
   chk_pol_invert: assert property (ok && !tx_lanes_oe_n && lane_swap_polarity_strap
      && lane_swap_polarity_strap_pull && $stable(retimer_active) && $past(retimer_active, 3)
      == retimer_active |-> tx_lanes == (rx3_ff ^ {4{retimer_active}}))
      else $error("polarity wrong");
   chk_retime_rate: assert property (ok && !tx_lanes_oe_n && $past(rx_rate, 4) == rx_rate
      |-> retimer_active == rx_rate.above_1g) else $error("crossover wrong");
   chk_term_auto: assert property (ok && output_termination_select !=
      output_termination_select_pull && $past(rx_rate, 4) == rx_rate |-> tx_term_sel ==
      (rx_rate.above_3g4 ? 2'h1 : (rx_rate.above_2g ? 2'h2 : 2'h0)))
      else $error("auto termination wrong");
   chk_sig_standby: assert property (ok && signal_detect_enable && idle_ff > 8'h64
      |-> tx_lanes_oe_n && !cdr_enable) else $error("no standby without clock");
endmodule : rlcc_chk
bind rlcc_top rlcc_chk u_chk (.*, .rx_rate(rate_class));
`default_nettype wire

//--- tb/rlcc_src.sv
// Purpose: video source model driving the four input lanes
// Assumes: link clock period 200 ns, edges fixed 0.5 ns after a ref_clk rising edge
// Notes:   clock stands still while run is low, as between frames
`timescale 1ns/1ps
`default_nettype none
module rlcc_src (
   input  wire logic                 run,
   output var rlcc_pkg::rlcc_lanes_s rx_lanes
);
   logic       lclk = 1'b0;
   logic [2:0] pat_ff = 3'h0;
   // offset start keeps link edges away from ref_clk edges
   initial begin
      #13;
      forever begin
         #100;
         if (run) lclk = ~lclk;
      end
   end
   // new data on every lane each link clock
   always @(posedge lclk) pat_ff <= pat_ff + 3'h3;
   assign rx_lanes = {lclk, pat_ff};
endmodule : rlcc_src
`default_nettype wire

//--- tb/rlcc_top_tb.sv
// Purpose: self-checking bench for rlcc_top
// Assumes: straps change only while resetn is low
// Notes:   three strap sets; the first after a 6-cycle reset, the others after 4000 cycles
`timescale 1ns/1ps
`default_nettype none
module rlcc_top_tb;
   // --------
   // stimulus and checks
   // --------
   logic ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, audio_in = 1'b0;
   logic run = 1'b1, signal_detect_enable, tx_lanes_oe_n, cdr_enable, retimer_active;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic lane_swap_polarity_strap, lane_swap_polarity_strap_pull, equalizer_strap_pin;
   logic equalizer_strap_pin_pull, output_termination_select, output_termination_select_pull;
   logic audio_return_output, audio_return_oe_n;
   logic [19:0] lane_eq_gain;
   logic [3:0] lane_eq_adapt;
   logic [1:0] tx_term_sel;
   logic [1:0] tm[3] = '{2'h0, 2'h2, 2'h1};
   rlcc_pkg::rlcc_lanes_s rx_lanes, tx_lanes, r1, r2, r3;
   rlcc_pkg::rlcc_rate_s rate_class = 3'b111;
   rlcc_pkg::rlcc_rate_s rt[3] = '{3'b000, 3'b110, 3'b111};
   int miscompares = 0, tests_run = 0;
   rlcc_top uut (.*);
   rlcc_src src (.run, .rx_lanes);
   always #12.5 ref_clk = ~ref_clk;
   // lane history, three edges deep
   always @(posedge ref_clk) begin
      r1 <= rx_lanes;
      r2 <= r1;
      r3 <= r2;
   end
   // strap code: 0 low, 1 high, 2 float
   function automatic logic [1:0] lv(input logic [1:0] s);
      return (s == 2'd2) ? 2'b01 : {2{s[0]}};
   endfunction : lv
   task automatic ck(input logic [23:0] g, x);
      tests_run++;
      if (g !== x) begin
         $display("[FAIL] %0t got %h expected %h", $time, g, x);
         miscompares++;
      end
   endtask : ck
   task automatic w(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : w
   task automatic wr(input logic [7:0] a, d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, x);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 ck(reg_rdata, x);
   endtask : rd
   // straps move only in reset
   task automatic rst(input logic [1:0] s, e, t, input logic d, input int n);
      resetn <= 1'b0;
      {lane_swap_polarity_strap, lane_swap_polarity_strap_pull} <= lv(s);
      {equalizer_strap_pin, equalizer_strap_pin_pull} <= lv(e);
      {output_termination_select, output_termination_select_pull} <= lv(t);
      signal_detect_enable <= d;
      w(n);
      ck({tx_lanes_oe_n, audio_return_oe_n}, 2'b11);
      @(posedge ref_clk) resetn <= 1'b1;
      w(14);
   endtask : rst
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   initial begin
      rst(2'd2, 2'd2, 2'd2, 1'b0, 6);
      rd(rlcc_pkg::REG_EQ_MODE, rlcc_pkg::EQ_MODE_RST);
      rd(8'h55, 8'h00);
      ck(lane_eq_adapt, 4'hF);
      for (int i = 0; i < 3; i++) begin
         rate_class <= rt[i];
         w(8);
         ck(tx_term_sel, tm[i]);
         ck(retimer_active, rt[i].above_1g);
      end
      audio_in <= 1'b1;
      w(4);
      ck(audio_return_output, 1'b1);
      wr(rlcc_pkg::REG_MISC, 8'h90);
      w(5);
      ck(audio_return_oe_n, 1'b1);
      ck(tx_lanes, {r3.d2, r3.clk, r3.d0, r3.d1});
      rd(rlcc_pkg::REG_STATUS, 8'h35);
      wr(rlcc_pkg::REG_EQ_GAIN, 8'h14);
      wr(rlcc_pkg::REG_EQ_MODE, 8'h33);
      w(3);
      ck({lane_eq_gain, lane_eq_adapt}, {{4{5'h0A}}, 4'h0});
      wr(rlcc_pkg::REG_ERR_CTL, 8'h03);
      w(4800);
      ck(tx_lanes, {r3.d2, {3{tx_lanes.d0}}});
      rd(rlcc_pkg::REG_ERR_L0, 8'hFF);
      rst(2'd0, 2'd1, 2'd1, 1'b1, 4000);
      rd(rlcc_pkg::REG_EQ_GAIN, rlcc_pkg::GAIN_RST);
      ck(lane_eq_gain, {4{rlcc_pkg::GAIN_14DB}});
      ck(tx_term_sel, 2'h0);
      ck(tx_lanes, {r3.d2, r3.clk, r3.d0, r3.d1});
      wr(rlcc_pkg::REG_TERM, 8'h28);
      w(3);
      ck(tx_term_sel, 2'h1);
      run <= 1'b0;
      w(120);
      ck({tx_lanes_oe_n, cdr_enable}, 2'b10);
      run <= 1'b1;
      w(60);
      ck(tx_lanes_oe_n, 1'b0);
      rst(2'd1, 2'd0, 2'd2, 1'b0, 4000);
      ck(lane_eq_gain, {4{rlcc_pkg::GAIN_7P5DB}});
      ck(tx_lanes, r3 ^ 4'hF);
      rate_class <= 3'b000;
      w(8);
      ck(tx_lanes, r3);
      summarize();
   end
   // watchdog: the run needs about 330 us
   initial begin
      #500000;
      miscompares++;
      summarize();
   end
endmodule : rlcc_top_tb
`default_nettype wire
